// *** design/multi_io_buffer_read.sv ***
// Device-side multi-line fast read engine over the page data buffer
`timescale 1ns/1ps
module multi_io_buffer_read (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial link pins
    input wire logic link_clk,
    input wire logic chip_sel_n,
    input wire mio_read_pkg::lines_t line_in,
    output mio_read_pkg::lines_t line_out,
    output mio_read_pkg::lines_t line_oe,
    // Mode straps from the status logic
    input wire logic read_mode_buf,
    input wire logic hw_protect_en,
    // Page buffer fill port and page advance request
    input wire logic buf_wr_en,
    input wire logic [11:0] buf_wr_addr,
    input wire logic [7:0] buf_wr_data,
    output logic page_adv
);
    ////////////////////////////////////////////////////////////////////////
    mio_read_pkg::rd_state_t s;
    mio_read_pkg::rd_state_t n;
    logic [7:0] mem [0:mio_read_pkg::BUF_BYTES-1];
    logic rise;
    logic fall;
    logic [3:0] din;
    logic [7:0] rbyte;
    logic [7:0] ncmd;
    logic quad_hit;
    logic [5:0] dum_bits;

    // Page buffer, loaded by the page-load logic beforehand
    always_ff @(posedge sys_clk) begin
        if (buf_wr_en && buf_wr_addr < 12'(mio_read_pkg::BUF_BYTES)) begin
            mem[buf_wr_addr] <= buf_wr_data;
        end
    end

    assign rise = s.ck[1] & ~s.ck[2];
    assign fall = ~s.ck[1] & s.ck[2];
    assign din = s.lin2;
    assign rbyte = (s.addr < mio_read_pkg::BUF_END) ?
        mem[s.addr[11:0]] : 8'hFF;
    assign ncmd = {s.cmd[6:0], din[0]};
    assign quad_hit = ncmd == mio_read_pkg::OP_QUAD_OUT ||
        ncmd == mio_read_pkg::OP_QUAD_OUT4 || ncmd == mio_read_pkg::OP_QUAD_IO;
    assign dum_bits = s.fourb ?
        (read_mode_buf ? mio_read_pkg::DUM_BUF4 : mio_read_pkg::DUM_CONT4) :
        (read_mode_buf ? mio_read_pkg::DUM_BUF : mio_read_pkg::DUM_CONT);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = s;
        n.page_adv = 1'b0;
        n.ck = {s.ck[1:0], link_clk};
        n.cs = {s.cs[0], chip_sel_n};
        n.lin1 = line_in;
        n.lin2 = s.lin1;
        if (s.cs[1]) begin
            n.phase = mio_read_pkg::ST_IDLE;
            n.doe = '0;
        end else begin
            case (s.phase)
                mio_read_pkg::ST_IDLE: begin
                    n.phase = mio_read_pkg::ST_CMD;
                    n.cnt = '0;
                    n.cmd = '0;
                end
                mio_read_pkg::ST_CMD: if (rise) begin
                    n.cmd = ncmd;
                    n.cnt = s.cnt + 6'h01;
                    if (n.cnt == mio_read_pkg::OPC_BITS) begin
                        n.cnt = '0;
                        n.phase = mio_read_pkg::ST_ADDR;
                        n.iw = mio_read_pkg::W_ONE;
                        n.fourb = 1'b0;
                        case (ncmd)
                            mio_read_pkg::OP_DUAL_OUT: begin
                                n.ow = mio_read_pkg::W_TWO;
                            end
                            mio_read_pkg::OP_DUAL_OUT4: begin
                                n.ow = mio_read_pkg::W_TWO;
                                n.fourb = 1'b1;
                            end
                            mio_read_pkg::OP_QUAD_OUT: begin
                                n.ow = mio_read_pkg::W_FOUR;
                            end
                            mio_read_pkg::OP_QUAD_OUT4: begin
                                n.ow = mio_read_pkg::W_FOUR;
                                n.fourb = 1'b1;
                            end
                            mio_read_pkg::OP_DUAL_IO: begin
                                n.ow = mio_read_pkg::W_TWO;
                                n.iw = mio_read_pkg::W_TWO;
                            end
                            mio_read_pkg::OP_DUAL_IO4: begin
                                n.ow = mio_read_pkg::W_TWO;
                                n.iw = mio_read_pkg::W_TWO;
                                n.fourb = 1'b1;
                            end
                            mio_read_pkg::OP_QUAD_IO: begin
                                n.ow = mio_read_pkg::W_FOUR;
                                n.iw = mio_read_pkg::W_FOUR;
                            end
                            default: n.phase = mio_read_pkg::ST_HOLD;
                        endcase
                        if (quad_hit && hw_protect_en) begin
                            n.phase = mio_read_pkg::ST_HOLD;
                        end
                    end
                end
                mio_read_pkg::ST_ADDR: if (rise) begin
                    // Top line carries the highest bit of each group
                    case (s.iw)
                        mio_read_pkg::W_TWO: n.addr = {s.addr[13:0], din[1:0]};
                        mio_read_pkg::W_FOUR: n.addr = {s.addr[11:0], din};
                        default: n.addr = {s.addr[14:0], din[0]};
                    endcase
                    n.cnt = s.cnt + {3'h0, s.iw};
                    if (n.cnt == mio_read_pkg::COL_BITS) begin
                        n.cnt = '0;
                        n.phase = mio_read_pkg::ST_DUMMY;
                    end
                end
                mio_read_pkg::ST_DUMMY: if (rise) begin
                    n.cnt = s.cnt + {3'h0, s.iw};
                    if (n.cnt == dum_bits) begin
                        n.phase = mio_read_pkg::ST_DATA;
                        n.bcnt = '0;
                        if (!read_mode_buf) begin
                            n.addr = '0;
                        end
                    end
                end
                mio_read_pkg::ST_DATA: if (fall) begin
                    if (s.bcnt == 4'h0) begin
                        if (read_mode_buf &&
                            s.addr >= mio_read_pkg::BUF_END) begin
                            n.doe = '0;
                            n.phase = mio_read_pkg::ST_HOLD;
                        end else begin
                            n.sh = rbyte;
                            n.bcnt = 4'h8;
                            if (!read_mode_buf &&
                                s.addr == mio_read_pkg::BUF_LAST) begin
                                n.addr = '0;
                                n.page_adv = 1'b1;
                            end else begin
                                n.addr = s.addr + 16'h0001;
                            end
                        end
                    end
                    if (n.phase == mio_read_pkg::ST_DATA) begin
                        // MSB first, on the top line
                        if (s.ow == mio_read_pkg::W_FOUR) begin
                            n.dout = n.sh[7:4];
                            n.doe = 4'hF;
                            n.sh = {n.sh[3:0], 4'h0};
                        end else begin
                            n.dout = {2'h0, n.sh[7:6]};
                            n.doe = 4'h3;
                            n.sh = {n.sh[5:0], 2'h0};
                        end
                        n.bcnt = n.bcnt - {1'b0, s.ow};
                    end
                end
                mio_read_pkg::ST_HOLD: n.doe = '0;
                default: n.phase = mio_read_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s <= '0;
            s.cs <= mio_read_pkg::CS_SYNC_RST;
        end else begin
            s <= n;
        end
    end

    assign line_out = s.dout;
    assign line_oe = s.doe;
    assign page_adv = s.page_adv;

    ////////////////////////////////////////////////////////////////////////
    property p_dual_lines;
        @(posedge sys_clk) disable iff (!nrst)
        (s.doe == 4'h3) |-> (s.ow == 3'h2 && s.phase == mio_read_pkg::ST_DATA);
    endproperty
    a_dual_lines: assert property (p_dual_lines)
        else $error("dual drive outside dual data phase");

    property p_quad_lines;
        @(posedge sys_clk) disable iff (!nrst)
        (s.doe == 4'hF) |-> (s.ow == 3'h4 && s.phase == mio_read_pkg::ST_DATA);
    endproperty
    a_quad_lines: assert property (p_quad_lines)
        else $error("quad drive outside quad data phase");

    property p_wp_block;
        @(posedge sys_clk) disable iff (!nrst)
        (s.phase == mio_read_pkg::ST_CMD && rise && !s.cs[1] &&
            s.cnt == 6'h07 && quad_hit && hw_protect_en)
            |=> (s.phase == mio_read_pkg::ST_HOLD && s.doe == 4'h0) [*8];
    endproperty
    a_wp_block: assert property (p_wp_block)
        else $error("quad read ran while protected");

    property p_cs_release;
        @(posedge sys_clk) disable iff (!nrst)
        s.cs[1] |=> (s.doe == 4'h0 && s.phase == mio_read_pkg::ST_IDLE);
    endproperty
    a_cs_release: assert property (p_cs_release)
        else $error("lines still driven after deselect");

    property p_fall_only;
        @(posedge sys_clk) disable iff (!nrst)
        (!fall && !s.cs[1]) |=> $stable(s.dout);
    endproperty
    a_fall_only: assert property (p_fall_only)
        else $error("data changed without a falling link edge");

    property p_cont_start;
        @(posedge sys_clk) disable iff (!nrst)
        (s.phase == mio_read_pkg::ST_DUMMY &&
            n.phase == mio_read_pkg::ST_DATA && !read_mode_buf)
            |=> (s.addr == 16'h0000);
    endproperty
    a_cont_start: assert property (p_cont_start)
        else $error("continuous read did not start at byte zero");

    property p_wrap;
        @(posedge sys_clk) disable iff (!nrst)
        s.page_adv |-> (s.addr == 16'h0000 && s.phase == mio_read_pkg::ST_DATA
            && $past(s.addr) == mio_read_pkg::BUF_LAST);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("page advance not at buffer end");

    property p_buf_end;
        @(posedge sys_clk) disable iff (!nrst)
        (s.phase == mio_read_pkg::ST_DATA && fall && !s.cs[1] &&
            s.bcnt == 4'h0 && read_mode_buf &&
            s.addr >= mio_read_pkg::BUF_END)
            |=> (s.doe == 4'h0 && s.phase == mio_read_pkg::ST_HOLD);
    endproperty
    a_buf_end: assert property (p_buf_end)
        else $error("lines not released after last buffer byte");

    c_quad_data: cover property (@(posedge sys_clk) disable iff (!nrst)
        s.doe == 4'hF);
    c_dual_data: cover property (@(posedge sys_clk) disable iff (!nrst)
        s.doe == 4'h3);
    c_page_adv: cover property (@(posedge sys_clk) disable iff (!nrst)
        s.page_adv);
    c_wp_hold: cover property (@(posedge sys_clk) disable iff (!nrst)
        s.phase == mio_read_pkg::ST_HOLD && hw_protect_en);
endmodule

// *** design/mio_read_pkg.sv ***
// Opcodes, sizes, reset values and carrier types for the multi-line reader
package mio_read_pkg;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_DUAL_OUT4 = 8'h3C;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_QUAD_OUT4 = 8'h6C;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO4 = 8'hBC;
    localparam logic [7:0] OP_QUAD_IO = 8'hEB;
    localparam int BUF_BYTES = 2112;
    localparam logic [15:0] BUF_END = 16'h0840;
    localparam logic [15:0] BUF_LAST = 16'h083F;
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] COL_BITS = 6'h10;
    localparam logic [5:0] DUM_BUF = 6'h08;
    localparam logic [5:0] DUM_CONT = 6'h20;
    localparam logic [5:0] DUM_BUF4 = 6'h18;
    localparam logic [5:0] DUM_CONT4 = 6'h28;
    localparam logic [2:0] W_ONE = 3'h1;
    localparam logic [2:0] W_TWO = 3'h2;
    localparam logic [2:0] W_FOUR = 3'h4;
    localparam logic [1:0] CS_SYNC_RST = 2'h3;

    typedef struct packed {
        logic line_three;
        logic line_two;
        logic line_one;
        logic line_zero;
    } lines_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA = 3'b100,
        ST_HOLD = 3'b101
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [2:0] ck;
        logic [1:0] cs;
        lines_t lin1;
        lines_t lin2;
        logic [7:0] cmd;
        logic [5:0] cnt;
        logic [2:0] iw;
        logic [2:0] ow;
        logic fourb;
        logic [15:0] addr;
        logic [7:0] sh;
        logic [3:0] bcnt;
        lines_t dout;
        lines_t doe;
        logic page_adv;
    } rd_state_t;
endpackage

// *** sim/spi_host_model.sv ***
// Host-side link master that frames multi-line buffer reads
`timescale 1ns/1ps
module spi_host_model (
    // Pins toward the device
    output logic link_clk,
    output logic chip_sel_n,
    output mio_read_pkg::lines_t line_in,
    // Device drive on the shared lines
    input wire mio_read_pkg::lines_t line_out,
    input wire mio_read_pkg::lines_t line_oe
);
    logic [3:0] hv = 4'h0;
    logic [3:0] hen = 4'h0;
    logic tog = 1'b0;
    logic [8:0] got[$];
    wire [3:0] dev_o = line_out;
    wire [3:0] dev_e = line_oe;
    wire [3:0] w = (dev_e & dev_o) |
        (~dev_e & ((hen & hv) | (~hen & {4{tog}})));

    ////////////////////////////////////////////////////////////////////////
    // Undriven lines show a pattern that changes every cycle
    always #10 tog = ~tog;
    assign line_in = mio_read_pkg::lines_t'(w);
    initial begin
        link_clk = 1'b0;
        chip_sel_n = 1'b1;
    end

    task automatic tick();
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One read frame; each byte is {any enable seen, data}
    task automatic frame(input logic [7:0] op, input logic [15:0] col,
                         input int aw, input int nd, input int dw,
                         input int nb);
        logic [8:0] b;
        got.delete();
        #7 chip_sel_n = 1'b0;
        #100 hen = 4'h1;
        for (int i = 7; i >= 0; i--) begin
            hv = {3'h0, op[i]};
            tick();
        end
        hen = (aw == 4) ? 4'hF : ((aw == 2) ? 4'h3 : 4'h1);
        for (int i = 16 - aw; i >= 0; i -= aw) begin
            hv = 4'(col >> i);
            tick();
        end
        hen = 4'h0;
        repeat (nd) tick();
        for (int k = 0; k < nb; k++) begin
            b = 9'h000;
            repeat (8 / dw) begin
                #80 link_clk = 1'b1;
                #80 b[8] = b[8] | (|dev_e);
                b[7:0] = 8'({b[7:0], 4'h0} >> (4 - dw)) |
                    8'(w & 4'((1 << dw) - 1));
                link_clk = 1'b0;
            end
            got.push_back(b);
        end
        #80 chip_sel_n = 1'b1;
        #200;
    endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the multi-line buffer read engine
`timescale 1ns/1ps
module tb;
    localparam int N = mio_read_pkg::BUF_BYTES;
    logic sys_clk, nrst, read_mode_buf, hw_protect_en, buf_wr_en;
    logic link_clk, chip_sel_n, page_adv;
    logic [11:0] buf_wr_addr;
    logic [7:0] buf_wr_data;
    mio_read_pkg::lines_t line_in, line_out, line_oe;
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 62307;
    int adv_cnt = 0;
    logic [7:0] mem [N];
    // Last entry is an opcode this block does not serve: it must be refused
    logic [7:0] ops [8] = '{8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC,
        8'hEB, 8'h0B};
    int aw [8] = '{1, 1, 1, 1, 2, 2, 4, 1};
    int dw [8] = '{2, 2, 4, 4, 2, 2, 4, 2};
    bit four [8] = '{0, 1, 0, 1, 0, 1, 0, 0};

    multi_io_buffer_read i_multi_io_buffer_read (.sys_clk(sys_clk),
        .nrst(nrst), .link_clk(link_clk), .chip_sel_n(chip_sel_n),
        .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
        .read_mode_buf(read_mode_buf), .hw_protect_en(hw_protect_en),
        .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr),
        .buf_wr_data(buf_wr_data), .page_adv(page_adv));
    spi_host_model i_spi_host_model (.link_clk(link_clk),
        .chip_sel_n(chip_sel_n), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (page_adv === 1'b1) adv_cnt++;

    task automatic check(input string what, input logic [8:0] seen,
                         input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Frames one read; compares each served byte with the buffer model and checks released bytes saw no enable
    task automatic run(input int i, input logic [15:0] col, input int nb);
        int a;
        logic rel;
        logic [8:0] g;
        logic [8:0] e;
        @(posedge sys_clk);
        #2;
        a = four[i] ? (read_mode_buf ? 24 : 40) : (read_mode_buf ? 8 : 32);
        i_spi_host_model.frame(ops[i], col, aw[i], a / aw[i], dw[i], nb);
        for (int k = 0; k < nb; k++) begin
            a = (read_mode_buf ? int'(col) : 0) + k;
            rel = (hw_protect_en && dw[i] == 4) || (read_mode_buf && a >= N)
                || i == 7;
            e = {1'b1, mem[a % N]};
            g = i_spi_host_model.got[k];
            if (rel) check("released", {g[8], 8'h00}, 9'h000);
            else if (k == 0) check("first", g, e);
            else check("byte", g, e);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, hw_protect_en, buf_wr_en, buf_wr_addr, buf_wr_data} = '0;
        read_mode_buf = 1'b1;
        repeat (5) @(posedge sys_clk);
        #2 nrst = 1'b1;
        for (int a = 0; a < N; a++) begin
            mem[a] = 8'($random(seed));
            @(posedge sys_clk);
            #2 buf_wr_en = 1'b1;
            buf_wr_addr = 12'(a);
            buf_wr_data = mem[a];
        end
        @(posedge sys_clk);
        #2 buf_wr_en = 1'b0;
        repeat (5) @(posedge sys_clk);
        for (int i = 0; i < 7; i++) run(i, 16'({$random(seed)} % 2100), 3);
        run(4, 16'h083E, 4);
        run(7, 16'h0010, 2);
        @(posedge sys_clk);
        #2 hw_protect_en = 1'b1;
        for (int i = 0; i < 7; i++) run(i, 16'h0010, 2);
        @(posedge sys_clk);
        #2 hw_protect_en = 1'b0;
        check("advance", 9'(adv_cnt), 9'h000);
        @(posedge sys_clk);
        #2 read_mode_buf = 1'b0;
        for (int i = 0; i < 6; i++) run(i, 16'h0123, 2);
        run(6, 16'h0100, N + 2);
        check("advance", 9'(adv_cnt), 9'h001);
        conclude();
    end

    initial begin
        #2_000_000;
        error_cnt++;
        conclude();
    end
endmodule
